// ===== verilog/aocr_pkg.sv
package aocr_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] AOCR_OFS_DATA_CFG = 8'h14;
  localparam logic [7:0] AOCR_OFS_TERM = 8'h15;
  localparam logic [7:0] AOCR_OFS_PHASE = 8'h16;
  localparam logic [7:0] AOCR_OFS_PAT_LOW = 8'h19;
  localparam logic [7:0] AOCR_OFS_PAT_HIGH = 8'h1A;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] AOCR_RST_DATA_CFG = 8'h00;
  localparam logic [7:0] AOCR_RST_TERM = 8'h00;
  localparam logic [7:0] AOCR_RST_PHASE = 8'h03;
  localparam logic [7:0] AOCR_RST_PAT_LOW = 8'h00;
  localparam logic [7:0] AOCR_RST_PAT_HIGH = 8'h00;
  localparam logic [9:0] AOCR_RST_DEG = 10'h0B4;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int AOCR_FMT_LSB = 0;
  localparam int AOCR_INV_BIT = 2;
  localparam int AOCR_LOWPWR_BIT = 6;
  localparam int AOCR_TERM_LSB = 4;
  localparam int AOCR_PHASE_LSB = 0;
  localparam logic [7:0] AOCR_MASK_DATA_CFG = 8'h47;
  localparam logic [7:0] AOCR_MASK_TERM = 8'h30;
  localparam logic [7:0] AOCR_MASK_PHASE = 8'h0F;

  // ****************************************
  // Codes
  // ****************************************
  localparam logic [3:0] AOCR_PHASE_MAX = 4'hA;
  localparam logic [3:0] AOCR_TEST_USER = 4'h8;
  localparam logic [1:0] AOCR_FMT_OFFSET = 2'h0;
  localparam logic [1:0] AOCR_FMT_TWOS = 2'h1;
  localparam int AOCR_DATA_W = 10;

  // Register read or write request from the serial port decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aocr_req_t;

  // Settings presented to the output stage
  typedef struct packed {
    logic low_power;
    logic [1:0] termination;
    logic [3:0] phase_sel;
    logic [1:0] fmt;
    logic invert;
    logic [15:0] pattern;
  } aocr_cfg_t;

endpackage

// ===== verilog/aocr_reg8.sv
module aocr_reg8
  import aocr_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hFF
)
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] value
);

  typedef struct packed {
    logic [7:0] val_reg;
  } aocr_r8_state_t;

  aocr_r8_state_t st_reg;
  aocr_r8_state_t st_next;

  always_comb
  begin
    st_next = st_reg;
    // Unimplemented bits stay zero
    if (we)
    begin
      st_next.val_reg = wdata & WRITE_MASK;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      st_reg.val_reg <= RESET_VALUE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign value = st_reg.val_reg;

endmodule

// ===== verilog/aocr_top.sv
// How it works
// - Bits 3:0 of register 0x16 hold the clock phase code, 0000 to 1010, choosing the divider phase.
// - The phase register resets to 0x03, putting the clock 180 degrees from the data edge.
// - Phase code 0000 puts the clock edge on the data transition, zero degrees.
// - Phase code 0010 puts the clock edge 60 degrees after the data transition.
// - Phase code 0100 gives 240 degrees and code 0101 gives 300 degrees.
// - Register 0x19 holds pattern bits 7:0 and resets to 0x00.
// - Register 0x1A holds pattern bits 15:8, forming the 16-bit pattern with the low byte.
// - In user-pattern test mode the stored pattern replaces conversion data, then is formatted.
module aocr_top
  import aocr_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire aocr_req_t REQ,
  output logic [7:0] RDATA,
  output logic RVALID,
  input wire logic [3:0] TEST_MODE,
  input wire logic [AOCR_DATA_W-1:0] CONV_DATA,
  output aocr_cfg_t CFG,
  output logic [AOCR_DATA_W-1:0] OUT_DATA,
  output logic [3:0] PHASE_TAP,
  output logic [9:0] PHASE_DEG_DIV60
);

  // ****************************************
  // Register bank
  // ****************************************
  logic [7:0] data_cfg;
  logic [7:0] term;
  logic [7:0] phase;
  logic [7:0] pat_low;
  logic [7:0] pat_high;

  aocr_reg8 #(.RESET_VALUE(AOCR_RST_DATA_CFG), .WRITE_MASK(AOCR_MASK_DATA_CFG)) u_data_cfg
  (
    .CLK(CLK),
    .SRST(SRST),
    .we(REQ.wr && REQ.addr == AOCR_OFS_DATA_CFG),
    .wdata(REQ.wdata),
    .value(data_cfg)
  );

  aocr_reg8 #(.RESET_VALUE(AOCR_RST_TERM), .WRITE_MASK(AOCR_MASK_TERM)) u_term
  (
    .CLK(CLK),
    .SRST(SRST),
    .we(REQ.wr && REQ.addr == AOCR_OFS_TERM),
    .wdata(REQ.wdata),
    .value(term)
  );

  // Reset 0x03 means 180 degrees
  aocr_reg8 #(.RESET_VALUE(AOCR_RST_PHASE), .WRITE_MASK(AOCR_MASK_PHASE)) u_phase
  (
    .CLK(CLK),
    .SRST(SRST),
    .we(REQ.wr && REQ.addr == AOCR_OFS_PHASE),
    .wdata(REQ.wdata),
    .value(phase)
  );

  aocr_reg8 #(.RESET_VALUE(AOCR_RST_PAT_LOW), .WRITE_MASK(8'hFF)) u_pat_low
  (
    .CLK(CLK),
    .SRST(SRST),
    .we(REQ.wr && REQ.addr == AOCR_OFS_PAT_LOW),
    .wdata(REQ.wdata),
    .value(pat_low)
  );

  aocr_reg8 #(.RESET_VALUE(AOCR_RST_PAT_HIGH), .WRITE_MASK(8'hFF)) u_pat_high
  (
    .CLK(CLK),
    .SRST(SRST),
    .we(REQ.wr && REQ.addr == AOCR_OFS_PAT_HIGH),
    .wdata(REQ.wdata),
    .value(pat_high)
  );

  // ****************************************
  // Local state
  // ****************************************
  typedef struct packed {
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic [AOCR_DATA_W-1:0] out_reg;
    logic [3:0] tap_reg;
    logic [9:0] deg_reg;
    logic [3:0] test_s1_reg;
    logic [3:0] test_s2_reg;
  } aocr_state_t;

  aocr_state_t st_reg;
  aocr_state_t st_next;
  logic [15:0] pattern;
  logic [1:0] fmt;
  logic [AOCR_DATA_W-1:0] src;

  assign pattern = {pat_high, pat_low};
  assign fmt = data_cfg[AOCR_FMT_LSB +: 2];

  always_comb
  begin
    st_next = st_reg;
    // Test mode is a pin from outside: two stages before use
    st_next.test_s1_reg = TEST_MODE;
    st_next.test_s2_reg = st_reg.test_s1_reg;
    st_next.rvalid_reg = REQ.rd;
    case (REQ.addr)
      AOCR_OFS_DATA_CFG: st_next.rdata_reg = data_cfg;
      AOCR_OFS_TERM: st_next.rdata_reg = term;
      AOCR_OFS_PHASE: st_next.rdata_reg = phase;
      AOCR_OFS_PAT_LOW: st_next.rdata_reg = pat_low;
      AOCR_OFS_PAT_HIGH: st_next.rdata_reg = pat_high;
      default: st_next.rdata_reg = 8'h00;
    endcase
    if (!REQ.rd)
    begin
      st_next.rdata_reg = 8'h00;
    end
    // Pattern replaces conversion data in user mode
    if (st_reg.test_s2_reg == AOCR_TEST_USER)
    begin
      src = pattern[15 -: AOCR_DATA_W];
    end
    else
    begin
      src = CONV_DATA;
    end
    // Twos complement flips the MSB of offset binary
    if (fmt == AOCR_FMT_TWOS)
    begin
      src[AOCR_DATA_W-1] = ~src[AOCR_DATA_W-1];
    end
    if (data_cfg[AOCR_INV_BIT])
    begin
      src = ~src;
    end
    st_next.out_reg = src;
    // Phase codes above 1010 are clamped; degree is code x 60, except 0010 = 60
    if (phase[3:0] > AOCR_PHASE_MAX)
    begin
      st_next.tap_reg = AOCR_PHASE_MAX;
    end
    else
    begin
      st_next.tap_reg = phase[3:0];
    end
    case (st_next.tap_reg)
      4'h0: st_next.deg_reg = 10'h000;
      4'h2: st_next.deg_reg = 10'h03C;
      4'h3: st_next.deg_reg = 10'h0B4;
      4'h4: st_next.deg_reg = 10'h0F0;
      4'h5: st_next.deg_reg = 10'h12C;
      default: st_next.deg_reg = 10'(st_next.tap_reg * 60);
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      st_reg <= '0;
      st_reg.tap_reg <= AOCR_RST_PHASE[3:0];
      st_reg.deg_reg <= AOCR_RST_DEG;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign RDATA = st_reg.rdata_reg;
  assign RVALID = st_reg.rvalid_reg;
  assign OUT_DATA = st_reg.out_reg;
  assign PHASE_TAP = st_reg.tap_reg;
  assign PHASE_DEG_DIV60 = st_reg.deg_reg;
  assign CFG.low_power = data_cfg[AOCR_LOWPWR_BIT];
  assign CFG.termination = term[AOCR_TERM_LSB +: 2];
  assign CFG.phase_sel = phase[AOCR_PHASE_LSB +: 4];
  assign CFG.fmt = fmt;
  assign CFG.invert = data_cfg[AOCR_INV_BIT];
  assign CFG.pattern = pattern;

endmodule

// ===== verification/aocr_checker.sv
module aocr_checker
  import aocr_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire aocr_req_t REQ,
  input wire logic [7:0] RDATA,
  input wire logic RVALID,
  input wire logic [3:0] TEST_MODE,
  input wire logic [AOCR_DATA_W-1:0] CONV_DATA,
  input wire aocr_cfg_t CFG,
  input wire logic [AOCR_DATA_W-1:0] OUT_DATA,
  input wire logic [3:0] PHASE_TAP,
  input wire logic [9:0] PHASE_DEG_DIV60
);
  // Test mode crosses two sync flops, so skip checks until reset is 4 edges gone
  logic [3:0] rst_hist;
  always_ff @(posedge CLK) rst_hist <= {rst_hist[2:0], SRST};
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  a_reset_phase: assert property (disable iff (1'b0) SRST |=> PHASE_TAP == 4'h3)
    else $error("phase not 3 after reset");
  a_phase_tap: assert property (CFG.phase_sel <= 4'hA |=> PHASE_TAP == $past(CFG.phase_sel))
    else $error("phase tap mismatch");
  a_phase_zero: assert property (PHASE_TAP == 4'h0 |-> PHASE_DEG_DIV60 == 10'h000)
    else $error("code 0 not 0 deg");
  a_phase_sixty: assert property (PHASE_TAP == 4'h2 |-> PHASE_DEG_DIV60 == 10'h03C)
    else $error("code 2 not 60 deg");
  a_phase_far: assert property (PHASE_TAP == 4'h5 |-> PHASE_DEG_DIV60 == 10'h12C)
    else $error("code 5 not 300 deg");
  a_pattern_low: assert property (REQ.wr && REQ.addr == 8'h19 |=>
    CFG.pattern[7:0] == $past(REQ.wdata)) else $error("low byte lost");
  a_pattern_high: assert property (REQ.wr && REQ.addr == 8'h1A |=>
    CFG.pattern[15:8] == $past(REQ.wdata)) else $error("high byte lost");
  a_user_pattern: assert property (rst_hist == 4'h0 && $past(TEST_MODE, 3) == 4'h8 &&
    $past(CFG.fmt) == 2'h0 && !$past(CFG.invert) |-> OUT_DATA == $past(CFG.pattern[15:6]))
    else $error("pattern not driven");
  a_format_data: assert property (rst_hist == 4'h0 && $past(TEST_MODE, 3) == 4'h0 |->
    OUT_DATA == ($past(CONV_DATA) ^ {$past(CFG.fmt) == 2'h1, 9'h000} ^ {10{$past(CFG.invert)}}))
    else $error("data format wrong");
endmodule
bind aocr_top aocr_checker u_chk (.CLK(CLK), .SRST(SRST), .REQ(REQ), .RDATA(RDATA),
  .RVALID(RVALID), .TEST_MODE(TEST_MODE), .CONV_DATA(CONV_DATA), .CFG(CFG),
  .OUT_DATA(OUT_DATA), .PHASE_TAP(PHASE_TAP), .PHASE_DEG_DIV60(PHASE_DEG_DIV60));

// ===== verification/test_adc_output_config_regs.sv
`define CHK(a, b) n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end
module test_adc_output_config_regs
  import aocr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, srst = 1;
  aocr_req_t req = '0;
  logic [3:0] tmode = 4'h0;
  logic [9:0] conv = 10'h000, odata, exp;
  logic [7:0] rdata;
  logic rvalid;
  aocr_cfg_t cfg;
  logic [3:0] ptap;
  logic [9:0] pdeg;
  logic [15:0] pat;
  int err_count, n_tests, cyc, a;
  int mdl[int];
  aocr_top dut (.CLK(clk), .SRST(srst), .REQ(req), .RDATA(rdata), .RVALID(rvalid),
    .TEST_MODE(tmode), .CONV_DATA(conv), .CFG(cfg), .OUT_DATA(odata), .PHASE_TAP(ptap),
    .PHASE_DEG_DIV60(pdeg));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_count++;
      end_sim;
    end
  end
  // ****************************************
  // Model and bus tasks
  // ****************************************
  function automatic int msk(int r);
    return r == 20 ? 8'h47 : r == 21 ? 8'h30 : r == 22 ? 8'h0F : 8'hFF;
  endfunction
  function automatic int deg(int c);
    int t[11] = '{0, 60, 60, 180, 240, 300, 360, 420, 480, 540, 600};
    return t[c > 10 ? 10 : c];
  endfunction
  // Settings seen by the output stage, rebuilt from the register model
  function automatic aocr_cfg_t exp_cfg();
    logic [7:0] d;
    logic [7:0] t;
    logic [7:0] p;
    d = 8'(mdl[20]);
    t = 8'(mdl[21]);
    p = 8'(mdl[22]);
    return '{low_power: d[6], termination: t[5:4], phase_sel: p[3:0], fmt: d[1:0],
      invert: d[2], pattern: 16'((mdl[26] << 8) | mdl[25])};
  endfunction
  task automatic do_reset;
    srst = 1;
    repeat (5) @(posedge clk);
    #1 srst = 0;
    mdl = '{20: 0, 21: 0, 22: 3, 25: 0, 26: 0};
  endtask
  task automatic wr(input int r, input int d);
    @(posedge clk);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: r[7:0], wdata: d[7:0]};
    @(posedge clk);
    #1 req = '0;
    if (mdl.exists(r)) mdl[r] = d & msk(r);
  endtask
  task automatic rd(input int r);
    @(posedge clk);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: r[7:0], wdata: 8'h00};
    @(posedge clk);
    #1 req = '0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, 8'(mdl.exists(r) ? mdl[r] : 0))
    `CHK(cfg, exp_cfg())
  endtask
  task automatic end_sim;
    $display("err_count=%0d n_tests=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    void'($urandom(32'hDCF6));
    do_reset;
    for (int r = 19; r <= 27; r++) rd(r);
    for (int c = 0; c < 16; c++)
    begin
      wr(22, c);
      @(posedge clk);
      #1;
      `CHK(ptap, 4'(c > 10 ? 10 : c))
      `CHK(pdeg, 10'(deg(c)))
    end
    repeat (40)
    begin
      a = 19 + $urandom_range(8);
      if ($urandom_range(1)) wr(a, $urandom_range(255));
      else rd(a);
    end
    // Format and invert combos, test mode off
    for (int m = 0; m < 6; m++)
    begin
      wr(20, ((m / 3) << 2) | (m % 3));
      repeat (6)
      begin
        conv = 10'($urandom);
        exp = conv ^ (m % 3 == 1 ? 10'h200 : 10'h000) ^ (m / 3 ? 10'h3FF : 10'h000);
        @(posedge clk);
        #1;
        `CHK(odata, exp)
      end
    end
    wr(25, $urandom_range(255));
    wr(26, $urandom_range(255));
    wr(20, 0);
    tmode = 4'h8;
    repeat (3) @(posedge clk);
    #1 pat = 16'((mdl[26] << 8) | mdl[25]);
    `CHK(cfg.pattern, pat)
    `CHK(odata, pat[15:6])
    tmode = 4'h0;
    wr(22, 5);
    do_reset;
    rd(22);
    `CHK(ptap, 4'h3)
    end_sim;
  end
endmodule
